/* design/cantfw_follow.sv */
`timescale 1ns/10ps
`include "cantfw_params.svh"
// Counts dominant transmit edges whose echo line fails to follow in time.
module cantfw_follow #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] WINDOW = 16'h00FA,
   parameter logic [2:0] FAILS = 3'h4
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Observed lines, low is dominant.
   input wire logic active_in,
   input wire logic txd_in,
   input wire logic echo_in,
   output logic fault_out
);
   logic txd_q, txd_d;
   logic wait_q, wait_d;
   logic [WIDTH-1:0] cnt_q, cnt_d;
   logic [2:0] miss_q, miss_d;
   logic flt_q, flt_d;

   // A follow window opens on each falling transmit edge while active_in is high.
   always_comb begin
      txd_d = txd_in;
      wait_d = wait_q;
      cnt_d = cnt_q;
      miss_d = miss_q;
      flt_d = 1'b0;
      if (!active_in) begin
         wait_d = 1'b0;
         cnt_d = '0;
      end else if (txd_q && !txd_in) begin
         wait_d = 1'b1;
         cnt_d = '0;
      end else if (wait_q) begin
         if (!echo_in) begin
            wait_d = 1'b0;
            miss_d = '0;
         end else if (cnt_q >= WINDOW || txd_in) begin
            wait_d = 1'b0;
            if (miss_q + 3'h1 >= FAILS) begin
               flt_d = 1'b1;
               miss_d = '0;
            end else begin
               miss_d = miss_q + 3'h1;
            end
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         txd_q <= 1'b1;
         wait_q <= 1'b0;
         cnt_q <= '0;
         miss_q <= '0;
         flt_q <= 1'b0;
      end else begin
         txd_q <= txd_d;
         wait_q <= wait_d;
         cnt_q <= cnt_d;
         miss_q <= miss_d;
         flt_q <= flt_d;
      end
   end

   assign fault_out = flt_q;
endmodule

/* design/cantfw_params.svh */
`ifndef CANTFW_PARAMS_SVH
`define CANTFW_PARAMS_SVH
`define CANTFW_CLK_MHZ 125
`define CANTFW_TXD_DOM_US 2000
`define CANTFW_BUS_DOM_US 2000
`define CANTFW_FILTER_NS 1000
`define CANTFW_WAKE_US 1000
`define CANTFW_RESET_PULSE_US 2000
`define CANTFW_SUP_VALID_US 100
`define CANTFW_FOLLOW_NS 2000
`define CANTFW_FAIL_COUNT 4
`endif

/* design/cantfw_pkg.sv */
package cantfw_pkg;
   typedef enum logic [1:0] {
      CANTFW_OFF,
      CANTFW_STANDBY,
      CANTFW_NORMAL
   } cantfw_mode_t;
   typedef enum logic [2:0] {
      CANTFW_W_IDLE,
      CANTFW_W_DOM1,
      CANTFW_W_GAP,
      CANTFW_W_DOM2,
      CANTFW_W_DONE
   } cantfw_wake_t;
endpackage

/* design/cantfw_timer.sv */
`timescale 1ns/10ps
`include "cantfw_params.svh"
// Counts while a condition holds and flags when a limit is exceeded.
module cantfw_timer #(
   parameter int WIDTH = 20,
   parameter logic [WIDTH-1:0] LIMIT = 20'h00010
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Condition and result.
   input wire logic run_in,
   output logic expired_out
);
   logic [WIDTH-1:0] cnt_q, cnt_d;
   logic exp_q, exp_d;

   // Saturating counter that restarts whenever the condition drops.
   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (!run_in) begin
         cnt_d = '0;
      end else if (cnt_q < LIMIT) begin
         cnt_d = cnt_q + 1'b1;
      end else begin
         exp_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired_out = exp_q;
endmodule

/* design/cantfw_top.sv */
`timescale 1ns/10ps
`include "cantfw_params.svh"
// What this block does
// [RQ1] Transceiver off until activate bit written.
// [RQ2] Five faults disable the transmitter.
// [RQ3] Receiver path never disabled by faults.
// [RQ4] Long dominant transmit latches timeout, disables.
// [RQ5] Four unfollowed bus edges latch, disable.
// [RQ6] Long dominant bus latches flag only.
// [RQ7] Four unfollowed receive edges latch, disable.
// [RQ8] Latched faults hold off until cleared.
// [RQ9] Reset default wakes on bus pattern.
// [RQ10] Two filtered pulses with filtered gap.
// [RQ11] Both pulses inside wake window.
// [RQ12] Wake flagged when second pulse qualifies.
// [RQ13] Battery standby wake gives 2 ms reset.
// [RQ14] Listen-only disables transmitter, keeps reception.
// [RQ15] Loopback routes transmit input to receive.
// [RQ16] Software may mix loopback and listen-only.
// [RQ17] Regulator overvoltage leaves transceiver enabled.
// [RQ18] Standby: transmitter off, receive held high.
// [RQ19] Wake never enters normal mode alone.
// [RQ20] Filtered supply low sets flag, biases.
// [RQ21] Re-enable only with no other cause.
module cantfw_top #(
   parameter int RESET_PULSE_CYCLES =
      (`CANTFW_RESET_PULSE_US * `CANTFW_CLK_MHZ),
   parameter int TXD_DOM_CYCLES = (`CANTFW_TXD_DOM_US * `CANTFW_CLK_MHZ),
   parameter int BUS_DOM_CYCLES = (`CANTFW_BUS_DOM_US * `CANTFW_CLK_MHZ),
   parameter int WAKE_CYCLES = (`CANTFW_WAKE_US * `CANTFW_CLK_MHZ),
   parameter int SUP_VALID_CYCLES = (`CANTFW_SUP_VALID_US * `CANTFW_CLK_MHZ)
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Controller pins and bus receiver.
   input wire logic txd_in,
   input wire logic bus_rx_in,
   output logic rxd_out,
   output logic bus_tx_dominant_out,
   output logic tx_enable_out,
   output logic internal_bias_out,
   // Control bits.
   input wire logic transceiver_activate_in,
   input wire logic transceiver_standby_in,
   input wire logic listen_only_enable_in,
   input wire logic loopback_enable_in,
   input wire logic wake_pattern_disable_in,
   input wire logic battery_standby_in,
   input wire logic regulator_overvoltage_in,
   // Fault inputs.
   input wire logic thermal_shutdown_stage_one_in,
   input wire logic supply_below_low_in,
   // Flag clears, one-cycle strobes.
   input wire logic clr_tx_dominant_in,
   input wire logic clr_bus_recessive_in,
   input wire logic clr_bus_dominant_in,
   input wire logic clr_rx_recessive_in,
   input wire logic clr_supply_low_in,
   // Status.
   output logic tx_dominant_timeout_flag_out,
   output logic bus_stuck_recessive_flag_out,
   output logic bus_stuck_dominant_flag_out,
   output logic rx_stuck_recessive_flag_out,
   output logic transceiver_supply_low_flag_out,
   output logic transceiver_normal_mode_out,
   output logic wake_flag_out,
   output logic wake_interrupt_out,
   output logic system_reset_out
);
   localparam int FILTER_CYCLES =
      (`CANTFW_FILTER_NS * `CANTFW_CLK_MHZ + 999) / 1000;
   localparam int FOLLOW_CYCLES = (`CANTFW_FOLLOW_NS * `CANTFW_CLK_MHZ) / 1000;

   cantfw_pkg::cantfw_mode_t mode_q, mode_d;
   cantfw_pkg::cantfw_wake_t wst_q, wst_d;
   logic f_txd_q, f_txd_d, f_rec_q, f_rec_d, f_dom_q, f_dom_d;
   logic f_rxd_q, f_rxd_d, f_sup_q, f_sup_d;
   logic txen_q, txen_d, rxd_q, rxd_d, btx_q, btx_d, bias_q, bias_d;
   logic wflag_q, wflag_d, wint_q, wint_d, rst_q, rst_d;
   logic [19:0] win_q, win_d;
   logic [31:0] rcnt_q, rcnt_d;
   logic txd_exp, bus_exp, sup_exp, rec_evt, rxd_evt, active, norm_q, norm_d;
   logic rxd_eff;

   function automatic logic set_or_keep(input logic f, input logic s, input logic c);
      set_or_keep = s | (f & ~c);
   endfunction

   cantfw_timer #(.WIDTH(32), .LIMIT(32'(TXD_DOM_CYCLES))) u_txd_timer (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .run_in(active & ~txd_in), .expired_out(txd_exp));
   cantfw_timer #(.WIDTH(32), .LIMIT(32'(BUS_DOM_CYCLES))) u_bus_timer (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .run_in(active & ~bus_rx_in), .expired_out(bus_exp));
   cantfw_timer #(.WIDTH(32), .LIMIT(32'(SUP_VALID_CYCLES))) u_sup_timer (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .run_in(active & supply_below_low_in), .expired_out(sup_exp));
   cantfw_follow #(.WIDTH(16), .WINDOW(16'(FOLLOW_CYCLES)),
      .FAILS(3'(`CANTFW_FAIL_COUNT))) u_bus_follow (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .active_in(txen_q),
      .txd_in(txd_in), .echo_in(bus_rx_in), .fault_out(rec_evt));
   cantfw_follow #(.WIDTH(16), .WINDOW(16'(FOLLOW_CYCLES)),
      .FAILS(3'(`CANTFW_FAIL_COUNT))) u_rxd_follow (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .active_in(txen_q),
      .txd_in(txd_in), .echo_in(rxd_q), .fault_out(rxd_evt));

   assign active = (mode_q == cantfw_pkg::CANTFW_NORMAL);

   // Mode control; a wake never moves to normal on its own.
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         cantfw_pkg::CANTFW_OFF: begin
            if (transceiver_activate_in) begin
               mode_d = cantfw_pkg::CANTFW_NORMAL; // RQ1
            end
         end
         cantfw_pkg::CANTFW_NORMAL: begin
            if (transceiver_standby_in) begin
               mode_d = cantfw_pkg::CANTFW_STANDBY;
            end
         end
         cantfw_pkg::CANTFW_STANDBY: begin
            if (transceiver_activate_in && !transceiver_standby_in) begin
               mode_d = cantfw_pkg::CANTFW_NORMAL; // RQ19
            end
         end
         default: mode_d = cantfw_pkg::CANTFW_OFF;
      endcase
      norm_d = (mode_d == cantfw_pkg::CANTFW_NORMAL);
   end

   // Latched fault flags; a new event wins over a clear in the same cycle.
   always_comb begin
      f_txd_d = set_or_keep(f_txd_q, txd_exp, clr_tx_dominant_in); // RQ4
      f_rec_d = set_or_keep(f_rec_q, rec_evt, clr_bus_recessive_in); // RQ5
      f_dom_d = set_or_keep(f_dom_q, bus_exp, clr_bus_dominant_in); // RQ6
      f_rxd_d = set_or_keep(f_rxd_q, rxd_evt, clr_rx_recessive_in); // RQ7
      f_sup_d = set_or_keep(f_sup_q, sup_exp, clr_supply_low_in); // RQ20
   end

   // Transmitter enable; overvoltage of the regulator is not a cause.
   always_comb begin
      txen_d = norm_d & ~listen_only_enable_in & ~thermal_shutdown_stage_one_in // RQ14 RQ2 RQ17
         & ~f_txd_q & ~f_rec_q & ~f_rxd_q & ~f_sup_q // RQ8 RQ21
         & ~txd_exp & ~rec_evt & ~rxd_evt & ~sup_exp; // RQ2
      btx_d = txen_d & ~txd_in;
      bias_d = f_sup_d; // RQ20
      rxd_eff = loopback_enable_in ? txd_in : bus_rx_in; // RQ15 RQ16
      rxd_d = (mode_d == cantfw_pkg::CANTFW_STANDBY) ? 1'b1 : rxd_eff; // RQ18 RQ3
   end

   // Wake pattern detector in standby.
   always_comb begin
      wst_d = wst_q;
      win_d = win_q;
      if (mode_q != cantfw_pkg::CANTFW_STANDBY || wake_pattern_disable_in) begin // RQ9
         wst_d = cantfw_pkg::CANTFW_W_IDLE;
         win_d = '0;
      end else begin
         if (wst_q != cantfw_pkg::CANTFW_W_IDLE) begin
            win_d = win_q + 20'h00001;
         end
         case (wst_q)
            cantfw_pkg::CANTFW_W_IDLE: begin
               if (!bus_rx_in) begin
                  wst_d = cantfw_pkg::CANTFW_W_DOM1;
                  win_d = '0;
               end
            end
            cantfw_pkg::CANTFW_W_DOM1: begin
               if (bus_rx_in) begin
                  wst_d = (win_q >= 20'(FILTER_CYCLES)) ? cantfw_pkg::CANTFW_W_GAP
                     : cantfw_pkg::CANTFW_W_IDLE; // RQ10
               end
            end
            default: begin
               wst_d = wst_q;
            end
         endcase
         if (win_q >= 20'(WAKE_CYCLES)) begin
            wst_d = cantfw_pkg::CANTFW_W_IDLE; // RQ11
         end
      end
   end

   // Segment time restarts at every state change of the wake detector.
   logic [19:0] seg_q, seg_d;
   cantfw_pkg::cantfw_wake_t wst_n;
   always_comb begin
      seg_d = (wst_n != wst_q) ? 20'h00000 : seg_q + 20'h00001;
   end
   // Wake flag, interrupt and system reset pulse.
   always_comb begin
      wflag_d = wflag_q;
      wint_d = 1'b0;
      rst_d = 1'b0;
      rcnt_d = rcnt_q;
      if (rcnt_q != 32'h00000000) begin
         rcnt_d = rcnt_q - 32'h00000001;
         rst_d = 1'b1;
      end
      if (wst_q == cantfw_pkg::CANTFW_W_DONE && seg_q == 20'h00000) begin
         wflag_d = 1'b1; // RQ12
         if (battery_standby_in) begin
            rcnt_d = 32'(RESET_PULSE_CYCLES); // RQ13
            rst_d = 1'b1;
         end else begin
            wint_d = 1'b1;
         end
      end
      if (mode_q == cantfw_pkg::CANTFW_NORMAL) begin
         wflag_d = 1'b0;
      end
   end

   // Gap and second-pulse transitions overlay the first-pulse stage.
   always_comb begin
      wst_n = wst_d;
      if (mode_q == cantfw_pkg::CANTFW_STANDBY && !wake_pattern_disable_in
          && win_q < 20'(WAKE_CYCLES)) begin
         if (wst_q == cantfw_pkg::CANTFW_W_GAP && !bus_rx_in) begin
            wst_n = (seg_q >= 20'(FILTER_CYCLES)) ? cantfw_pkg::CANTFW_W_DOM2
               : cantfw_pkg::CANTFW_W_IDLE; // RQ10
         end else if (wst_q == cantfw_pkg::CANTFW_W_DOM2) begin
            if (bus_rx_in) begin
               wst_n = cantfw_pkg::CANTFW_W_IDLE;
            end else if (seg_q >= 20'(FILTER_CYCLES)) begin
               wst_n = cantfw_pkg::CANTFW_W_DONE; // RQ12
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mode_q <= cantfw_pkg::CANTFW_OFF;
         wst_q <= cantfw_pkg::CANTFW_W_IDLE;
         {f_txd_q, f_rec_q, f_dom_q, f_rxd_q, f_sup_q} <= 5'h00;
         {txen_q, btx_q, bias_q, wflag_q, wint_q, rst_q} <= 6'h00;
         rxd_q <= 1'b1;
         win_q <= '0;
         seg_q <= '0;
         rcnt_q <= '0;
         norm_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         wst_q <= wst_n;
         f_txd_q <= f_txd_d;
         f_rec_q <= f_rec_d;
         f_dom_q <= f_dom_d;
         f_rxd_q <= f_rxd_d;
         f_sup_q <= f_sup_d;
         txen_q <= txen_d;
         btx_q <= btx_d;
         bias_q <= bias_d;
         rxd_q <= rxd_d;
         win_q <= win_d;
         seg_q <= seg_d;
         wflag_q <= wflag_d;
         wint_q <= wint_d;
         rst_q <= rst_d;
         rcnt_q <= rcnt_d;
         norm_q <= norm_d;
      end
   end

   // Transmitter never on without normal mode or with flags other than bus dominant, and off from the cycle after listen-only.
   a_tx_gated: assert property ( // RQ8
      @(posedge clk_in) disable iff (sys_rst_in)
      txen_q |-> (mode_q == cantfw_pkg::CANTFW_NORMAL) && !f_txd_q && !f_rec_q
      && !f_rxd_q && !f_sup_q)
      else $error("transmitter on while disabled");
   a_listen_only: assert property ( // RQ14
      @(posedge clk_in) disable iff (sys_rst_in)
      listen_only_enable_in |=> !txen_q)
      else $error("transmitter on in listen-only");
   a_standby_rxd: assert property ( // RQ18
      @(posedge clk_in) disable iff (sys_rst_in)
      (mode_q == cantfw_pkg::CANTFW_STANDBY) |-> rxd_q)
      else $error("receive output not recessive in standby");
   a_loop_route: assert property ( // RQ15
      @(posedge clk_in) disable iff (sys_rst_in)
      (loopback_enable_in && mode_d != cantfw_pkg::CANTFW_STANDBY)
      |=> rxd_q == $past(txd_in))
      else $error("loopback not routed");
   a_dom_latch: assert property ( // RQ4
      @(posedge clk_in) disable iff (sys_rst_in)
      txd_exp |=> f_txd_q && !txen_q)
      else $error("timeout not latched");
   a_bus_dom_keep: assert property ( // RQ6
      @(posedge clk_in) disable iff (sys_rst_in)
      bus_exp |=> f_dom_q)
      else $error("bus dominant not latched");
   a_no_auto_norm: assert property ( // RQ19
      @(posedge clk_in) disable iff (sys_rst_in)
      (mode_q == cantfw_pkg::CANTFW_STANDBY && !transceiver_activate_in)
      |=> mode_q == cantfw_pkg::CANTFW_STANDBY)
      else $error("left standby without activate");
   a_reset_pulse: assert property ( // RQ13
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(rst_q) |-> rst_q [*8])
      else $error("reset pulse too short");
   a_power_off: assert property ( // RQ1
      @(posedge clk_in) disable iff (sys_rst_in)
      (mode_q == cantfw_pkg::CANTFW_OFF) |-> !txen_q)
      else $error("transmitter on before activate");
   // Regulator overvoltage alone never turns the transmitter off.
   a_ov_keeps_tx: assert property ( // RQ17
      @(posedge clk_in) disable iff (sys_rst_in)
      (txen_q && regulator_overvoltage_in && mode_d == cantfw_pkg::CANTFW_NORMAL
      && !listen_only_enable_in && !thermal_shutdown_stage_one_in
      && !txd_exp && !rec_evt && !rxd_evt && !sup_exp) |=> txen_q)
      else $error("transmitter off on regulator overvoltage");

   assign rxd_out = rxd_q;
   assign bus_tx_dominant_out = btx_q;
   assign tx_enable_out = txen_q;
   assign internal_bias_out = bias_q;
   assign tx_dominant_timeout_flag_out = f_txd_q;
   assign bus_stuck_recessive_flag_out = f_rec_q;
   assign bus_stuck_dominant_flag_out = f_dom_q;
   assign rx_stuck_recessive_flag_out = f_rxd_q;
   assign transceiver_supply_low_flag_out = f_sup_q;
   assign transceiver_normal_mode_out = norm_q;
   assign wake_flag_out = wflag_q;
   assign wake_interrupt_out = wint_q;
   assign system_reset_out = rst_q;
endmodule

/* testbench/cantfw_bus_model.sv */
`timescale 1ns/10ps
// Bus nodes on the far side: echo the driven level promptly or late, or misbehave on command.
module cantfw_bus_model (
   // Clock.
   input wire logic clk_in,
   // Driven level and fault controls.
   input wire logic tx_dom_in,
   input wire logic force_dom_in,
   input wire logic stuck_rec_in,
   input wire logic slow_in,
   // Bus receiver level, low is dominant.
   output logic bus_rx_out
);
   logic [3:0] dly_q = 4'h0;
   // Delay line lets the bus answer late, as a long network would.
   always_ff @(posedge clk_in) begin
      dly_q <= {dly_q[2:0], tx_dom_in};
   end
   // The terminated bus idles recessive, so a stuck or released bus reads high.
   assign bus_rx_out = stuck_rec_in ? 1'b1 : ~((slow_in ? dly_q[3] : tx_dom_in) | force_dom_in);
endmodule

/* testbench/cantfw_top_tb.sv */
`timescale 1ns/10ps
`include "cantfw_params.svh"
// Self-checking bench for the fault and wake supervisor.
module cantfw_top_tb;
   localparam int FILT = `CANTFW_FILTER_NS * `CANTFW_CLK_MHZ / 1000;
   localparam int RSTP = 60;
   localparam int TO = 0, BR = 1, BD = 2, RR = 3, SL = 4, TE = 5, RX = 6, NM = 7, WK = 8;
   localparam int BI = 9;
   localparam int BT = 10, IC = 11, RC = 12;
   typedef struct {int idx; int exp;} cantfw_note_t;
   logic clk_in, sys_rst_in, txd, bus_rx, act, stby, lo, lb, bat, ov, tsd, sup;
   logic fdom, srec, slow, rxd, btx, txen, bias, f_to, f_br, f_bd, f_rr, f_sl, norm, wk, wint;
   logic srst, wpd;
   logic [4:0] clr;
   logic [10:0] st;
   int failures = 0, compares = 0, intr_cnt = 0, rst_cnt = 0, seed = 32'h55A3, i;
   cantfw_note_t q[$];
   event chk_ev;
   assign st = {btx, bias, wk, norm, rxd, txen, f_sl, f_rr, f_bd, f_br, f_to};
   // Design with short timers so the run stays brief.
   cantfw_top #(.RESET_PULSE_CYCLES(RSTP), .TXD_DOM_CYCLES(400), .BUS_DOM_CYCLES(300),
      .WAKE_CYCLES(600), .SUP_VALID_CYCLES(50)) dut_u (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .txd_in(txd), .bus_rx_in(bus_rx),
      .rxd_out(rxd), .bus_tx_dominant_out(btx), .tx_enable_out(txen),
      .internal_bias_out(bias), .transceiver_activate_in(act),
      .transceiver_standby_in(stby), .listen_only_enable_in(lo), .loopback_enable_in(lb),
      .wake_pattern_disable_in(wpd), .battery_standby_in(bat),
      .regulator_overvoltage_in(ov), .thermal_shutdown_stage_one_in(tsd),
      .supply_below_low_in(sup), .clr_tx_dominant_in(clr[0]), .clr_bus_recessive_in(clr[1]),
      .clr_bus_dominant_in(clr[2]), .clr_rx_recessive_in(clr[3]),
      .clr_supply_low_in(clr[4]), .tx_dominant_timeout_flag_out(f_to),
      .bus_stuck_recessive_flag_out(f_br), .bus_stuck_dominant_flag_out(f_bd),
      .rx_stuck_recessive_flag_out(f_rr), .transceiver_supply_low_flag_out(f_sl),
      .transceiver_normal_mode_out(norm), .wake_flag_out(wk), .wake_interrupt_out(wint),
      .system_reset_out(srst));
   // Far-side bus nodes.
   cantfw_bus_model model_u (.clk_in(clk_in), .tx_dom_in(btx), .force_dom_in(fdom),
      .stuck_rec_in(srec), .slow_in(slow), .bus_rx_out(bus_rx));
   // Clock at 125 MHz.
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic note(input int idx, input int exp);
      q.push_back('{idx, exp});
      ->chk_ev;
   endtask
   task automatic check(input int idx, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t item %0d got %0h expected %0h", $time, idx, got, exp);
      end
   endtask
   task automatic pulse_clr(input int b);
      clr[b] <= 1'b1;
      cyc(1);
      clr[b] <= 1'b0;
      cyc(3);
   endtask
   // One transmit dominant pulse, with the bus stuck recessive or not.
   task automatic txp(input logic rec);
      srec <= rec;
      txd <= 1'b0;
      cyc(260);
      txd <= 1'b1;
      cyc(20);
   endtask
   task automatic dom(input int n, input int g);
      fdom <= 1'b1;
      cyc(n);
      fdom <= 1'b0;
      cyc(g);
   endtask
   task automatic conclude;
      $display("Counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Monitor checks every queued expectation except the two noted just before conclude, oldest first, once outputs have settled.
   initial begin
      cantfw_note_t n;
      forever begin
         @(chk_ev);
         #1;
         while (q.size() > 0) begin
            n = q.pop_front();
            check(n.idx, n.idx < 11 ? st[n.idx] : (n.idx == 11 ? intr_cnt : rst_cnt), n.exp);
         end
      end
   end
   // Counts cycles of the interrupt and of the system reset pulse.
   always @(posedge clk_in) begin
      if (wint === 1'b1) intr_cnt++;
      if (srst === 1'b1) rst_cnt++;
   end
   // Watchdog cuts a hang well beyond the expected run length.
   initial begin
      cyc(30000);
      failures++;
      $display("MISMATCH %0t watchdog expired", $time);
      conclude();
   end
   // Main sequence.
   initial begin
      {sys_rst_in, txd} = 2'b11;
      {act, stby, lo, lb, bat, ov, tsd, sup, fdom, srec, slow, wpd} = 12'h000;
      clr = 5'h00;
      cyc(2);
      sys_rst_in <= 1'b0;
      cyc(20);
      note(TE, 0);
      note(NM, 0);
      note(RX, 1);
      act <= 1'b1;
      cyc(3);
      note(TE, 1);
      $display("Test power-up done");
      txd <= 1'b0;
      cyc(50);
      note(RX, 0);
      cyc(370);
      note(TO, 1);
      note(TE, 0);
      note(BT, 0);
      note(BD, 1);
      txd <= 1'b1;
      cyc(10);
      pulse_clr(2);
      note(TE, 0);
      pulse_clr(0);
      note(TO, 0);
      note(TE, 1);
      dom(310, 3);
      note(BD, 1);
      note(TE, 1);
      pulse_clr(2);
      $display("Test timeouts done");
      slow <= 1'b1;
      txp(1'b0);
      for (i = 0; i < 3; i++) txp(1'b1);
      txp(1'b0);
      for (i = 0; i < 3; i++) txp(1'b1);
      note(BR, 0);
      note(RR, 0);
      note(TE, 1);
      txp(1'b1);
      cyc(3);
      note(BR, 1);
      note(RR, 1);
      note(TE, 0);
      {srec, slow} <= 2'b00;
      pulse_clr(1);
      pulse_clr(3);
      note(TE, 1);
      $display("Test follow done");
      ov <= 1'b1;
      cyc(5);
      note(TE, 1);
      {tsd, fdom} <= 2'b11;
      cyc(3);
      note(TE, 0);
      note(RX, 0);
      {tsd, fdom} <= 2'b00;
      cyc(3);
      note(TE, 1);
      sup <= 1'b1;
      cyc(40);
      note(SL, 0);
      cyc(20);
      note(SL, 1);
      note(BI, 1);
      note(TE, 0);
      sup <= 1'b0;
      cyc(5);
      pulse_clr(4);
      note(BI, 0);
      note(TE, 1);
      $display("Test supply done");
      {lo, fdom} <= 2'b11;
      cyc(3);
      note(TE, 0);
      note(RX, 0);
      {lb, fdom} <= 2'b10;
      for (i = 0; i < 16; i++) begin
         txd <= 1'($random(seed));
         cyc(2);
         note(RX, txd);
         note(BT, 0);
      end
      {lb, lo, txd} <= 3'b001;
      cyc(3);
      pulse_clr(1);
      pulse_clr(3);
      note(TE, 1);
      $display("Test listen loop done");
      stby <= 1'b1;
      dom(3, 700);
      note(TE, 0);
      note(NM, 0);
      dom(100, 130);
      dom(100, 700);
      note(WK, 0);
      dom(130, 400);
      dom(200, 700);
      note(WK, 0);
      dom(130, 130);
      fdom <= 1'b1;
      cyc(FILT + 8);
      note(WK, 1);
      note(IC, 1);
      note(RX, 1);
      note(NM, 0);
      fdom <= 1'b0;
      cyc(5);
      note(RC, 0);
      stby <= 1'b0;
      cyc(3);
      note(NM, 1);
      note(WK, 0);
      {stby, bat, wpd} <= 3'b111;
      dom(130, 130);
      dom(FILT + 8, 700);
      note(WK, 0);
      note(RC, 0);
      wpd <= 1'b0;
      dom(130, 130);
      dom(FILT + 8, RSTP + 10);
      note(RC, RSTP + 1);
      note(IC, 1);
      $display("Test wake done");
      conclude();
   end
endmodule
